// [core/t1tsl_pkg.sv]
package t1tsl_pkg;
    // ------------------------------------------------------------
    // Register port geometry and device map
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 9;
    localparam int unsigned DATA_W = 8;
    localparam logic [8:0] OFF_MON_SEL  = 9'h189;
    localparam logic [8:0] OFF_LSTAT    = 9'h190;
    localparam logic [8:0] OFF_IMASK    = 9'h1A0;
    localparam logic [8:0] OFF_MON_BYTE = 9'h1BB;
    localparam logic [8:0] OFF_LOOP0    = 9'h1D0;
    localparam logic [8:0] OFF_LOOP1    = 9'h1D1;
    localparam logic [8:0] OFF_LOOP2    = 9'h1D2;
    localparam logic [8:0] OFF_RT_STAT  = 9'h1F0;
    localparam logic [7:0] RST_BYTE     = 8'h00;
    localparam logic [7:0] MON_SEL_MASK = 8'h1F;
    // Latched status bit positions
    localparam int unsigned BIT_CLK_LOSS  = 0;
    localparam int unsigned BIT_CLK_BACK  = 1;
    localparam int unsigned BIT_MF        = 2;
    localparam int unsigned BIT_DENSITY   = 3;
    localparam int unsigned BIT_SLC       = 4;
    localparam int unsigned BIT_SLIP      = 5;
    localparam int unsigned BIT_EMPTY     = 6;
    localparam int unsigned BIT_FULL      = 7;
    // ------------------------------------------------------------
    // Timing and frame structure
    // ------------------------------------------------------------
    localparam int unsigned ACLK_PERIOD_NS = 100;
    localparam int unsigned LCLK_PERIOD_NS = 648;
    localparam int unsigned LOSS_PERIODS   = 3;
    localparam int unsigned LOSS_TIME_NS   = LOSS_PERIODS * LCLK_PERIOD_NS;
    localparam int unsigned LOSS_CYCLES    =
        (LOSS_TIME_NS + ACLK_PERIOD_NS - 1) / ACLK_PERIOD_NS;
    localparam logic [7:0] LAST_BIT       = 8'hC0;
    localparam int unsigned CHANNELS      = 24;
    localparam logic [6:0] D4_MF_FRAMES   = 7'h0C;
    localparam logic [6:0] ESF_MF_FRAMES  = 7'h18;
    localparam logic [6:0] SLC_MF_FRAMES  = 7'h48;
    // ------------------------------------------------------------
    // Controller registers on the AXI4-Lite side
    // ------------------------------------------------------------
    localparam logic [7:0] HOFF_CMD    = 8'h00;
    localparam logic [7:0] HOFF_WDATA  = 8'h04;
    localparam logic [7:0] HOFF_STAT   = 8'h08;
    localparam int unsigned CMD_WR_BIT = 16;
    localparam int unsigned STAT_BUSY  = 0;
    localparam int unsigned STAT_INT   = 1;
    localparam int unsigned STAT_RD_LSB = 8;
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        H_IDLE   = 2'b01,
        H_ACCESS = 2'b10
    } t1tsl_hstate_e;
endpackage

// [core/t1tsl_if.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Parallel register port between controller and framer port
// ----------------------------------------------------------------
interface t1tsl_if;
    logic       req;    // Access request, held until ack
    logic       wr;     // 1 write, 0 read
    logic [8:0] addr;   // Register offset
    logic [7:0] wdata;  // Write byte
    logic [7:0] rdata;  // Read byte, valid with ack
    logic       ack;    // One-cycle answer
    logic       int_n;  // Interrupt, active low

    modport dev  (input req, wr, addr, wdata, output rdata, ack, int_n);
    modport host (output req, wr, addr, wdata, input rdata, ack, int_n);
endinterface

// [core/t1tsl_dev.sv]
// Function
// R1: Set bit holds until one written
// R2: Cleared bit waits for new event
// R3: Real-time reads steady, no side effect
// R4: Interrupt low while unmasked bit set
// R5: Clear works while condition persists
// R6: Loss after three silent line periods
// R7: Loss pin follows condition, not flag
// R8: Flag when line clock returns
// R9: Flag at each multiframe boundary
// R10: Density violation sets flag
// R11: SLC flag once per 72 frames
// R12: Slip flag on repeat or discard
// R13: Empty and full flags from store
// R14: Mask bit gates matching status bit
// R15: Looped channels take received data
// R16: Enable bits map channels ascending
// R17: System keeps both directions synchronised
// R18: Any channel subset may loop
// R19: Select holds channel minus one
// R20: First sent bit lands in bit 7
// R21: Zero in upper select bits
// R22: Monitor byte refreshed every frame
`timescale 1ns/1ps
module t1tsl_dev
(
    input  wire logic aclk,              // System clock
    input  wire logic aresetn,           // Synchronous reset, low
    t1tsl_if.dev      rp,                // Register port
    input  wire logic tx_line_clock,     // Sampled line clock
    input  wire logic tx_frame_sync,     // Marks framing bit
    input  wire logic tx_backplane_data, // Backplane bit
    input  wire logic rx_line_data,      // Received line bit
    input  wire logic d4_mode,           // 1 D4, 0 ESF
    input  wire logic slc_enable,        // SLC insertion on
    input  wire logic density_violation, // Checker event pulse
    input  wire logic store_slip,        // Store slip pulse
    input  wire logic store_empty,       // Store repeat pulse
    input  wire logic store_full,        // Store discard pulse
    input  wire logic loss_pin_enable,   // Enables loss pin
    output logic      tx_line_data,      // Outgoing line bit
    output logic      tx_clock_loss_pin  // Clock loss pin
);
    import t1tsl_pkg::*;

    // Channel 0..23 of a bit position 1..192
    function automatic logic [4:0] chan_of(input logic [7:0] pos);
        return 5'((pos - 8'h01) >> 3);
    endfunction

    // ------------------------------------------------------------
    // Line clock watch
    // ------------------------------------------------------------
    logic       lclk_q, lclk_d;
    logic [7:0] idle_q, idle_d;
    logic       loss_q, loss_d;
    logic       edge_any, rise;

    // Saturating idle counter; any level change restarts it
    always_comb
    begin
        edge_any = tx_line_clock ^ lclk_q;
        rise     = tx_line_clock & ~lclk_q;
        lclk_d   = tx_line_clock;
        idle_d   = idle_q;
        loss_d   = loss_q;
        if (edge_any)
        begin
            idle_d = 8'h00;
            // R8: activity ends loss
            loss_d = 1'b0;
        end
        else if (idle_q == 8'(LOSS_CYCLES - 1))
        begin
            // R6: silence declares loss
            loss_d = 1'b1;
        end
        else
        begin
            idle_d = idle_q + 8'h01;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            lclk_q <= 1'b0;
            idle_q <= 8'h00;
            loss_q <= 1'b0;
        end
        else
        begin
            lclk_q <= lclk_d;
            idle_q <= idle_d;
            loss_q <= loss_d;
        end
    end

    // ------------------------------------------------------------
    // Frame counters, loopback and monitor
    // ------------------------------------------------------------
    logic [7:0]  bit_q, bit_d;
    logic [6:0]  mf_q, mf_d, slc_q, slc_d;
    logic        out_q, out_d;
    logic [7:0]  shift_q, shift_d, mon_q, mon_d;
    logic        mf_evt, slc_evt, obit;
    logic [23:0] loop_q;
    logic [7:0]  sel_q;
    logic [6:0]  mf_len;

    // Everything advances on the rising line edge only
    always_comb
    begin
        bit_d   = bit_q;
        mf_d    = mf_q;
        slc_d   = slc_q;
        out_d   = out_q;
        shift_d = shift_q;
        mon_d   = mon_q;
        mf_evt  = 1'b0;
        slc_evt = 1'b0;
        obit    = tx_backplane_data;
        mf_len  = d4_mode ? D4_MF_FRAMES : ESF_MF_FRAMES;
        if (rise)
        begin
            bit_d = (tx_frame_sync || bit_q == LAST_BIT) ? 8'h00 : bit_q + 8'h01;
            if (bit_d == 8'h00)
            begin
                mf_d  = (mf_q >= mf_len - 7'h01) ? 7'h00 : mf_q + 7'h01;
                slc_d = (slc_q == SLC_MF_FRAMES - 7'h01) ? 7'h00 : slc_q + 7'h01;
                // R9: boundary each wrap
                mf_evt  = (mf_d == 7'h00);
                // R11: once per SLC multiframe
                slc_evt = (slc_d == 7'h00) & slc_enable;
            end
            else
            begin
                // R15: R16: R18: per-channel substitution, any set
                if (loop_q[chan_of(bit_d)])
                begin
                    obit = rx_line_data;
                end
                // R19: only the low five select bits count
                if (chan_of(bit_d) == sel_q[4:0])
                begin
                    // R20: shift left so first bit ends in bit 7
                    shift_d = {shift_q[6:0], obit};
                    // R22: load after eighth bit
                    if (bit_d[2:0] == 3'b000)
                    begin
                        mon_d = {shift_q[6:0], obit};
                    end
                end
            end
            out_d = obit;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bit_q   <= 8'h00;
            mf_q    <= 7'h00;
            slc_q   <= 7'h00;
            out_q   <= 1'b0;
            shift_q <= RST_BYTE;
            mon_q   <= RST_BYTE;
        end
        else
        begin
            bit_q   <= bit_d;
            mf_q    <= mf_d;
            slc_q   <= slc_d;
            out_q   <= out_d;
            shift_q <= shift_d;
            mon_q   <= mon_d;
        end
    end

    assign tx_line_data = out_q;

    // ------------------------------------------------------------
    // Register port, status and interrupt
    // ------------------------------------------------------------
    logic [7:0]  lstat_q, lstat_d, mask_q, mask_d, sel_d, rd_q, rd_d;
    logic [23:0] loop_d;
    logic        ack_q, ack_d, intn_q, intn_d, pin_q, pin_d;
    logic [7:0]  set, clr;
    logic        take, wtake;

    // Writes land at the take edge; reads never touch status
    always_comb
    begin
        take   = rp.req & ~ack_q;
        wtake  = take & rp.wr;
        ack_d  = take;
        sel_d  = sel_q;
        mask_d = mask_q;
        loop_d = loop_q;
        rd_d   = rd_q;
        clr    = 8'h00;
        set    = 8'h00;
        set[BIT_CLK_LOSS] = loss_d & ~loss_q;
        set[BIT_CLK_BACK] = loss_q & ~loss_d;
        set[BIT_MF]       = mf_evt;
        // R10: checker event
        set[BIT_DENSITY]  = density_violation;
        // R12: R13: store events
        set[BIT_SLIP]     = store_slip;
        set[BIT_EMPTY]    = store_empty;
        set[BIT_FULL]     = store_full;
        set[BIT_SLC]      = slc_evt;
        if (wtake)
        begin
            case (rp.addr)
                // R21: upper bits stored as written
                OFF_MON_SEL: sel_d = rp.wdata;
                // R1: ones clear, zeros keep
                OFF_LSTAT:   clr = rp.wdata;
                OFF_IMASK:   mask_d = rp.wdata;
                OFF_LOOP0:   loop_d[7:0] = rp.wdata;
                OFF_LOOP1:   loop_d[15:8] = rp.wdata;
                OFF_LOOP2:   loop_d[23:16] = rp.wdata;
                default:     ;
            endcase
        end
        if (take & ~rp.wr)
        begin
            case (rp.addr)
                OFF_MON_SEL:  rd_d = sel_q;
                OFF_LSTAT:    rd_d = lstat_q;
                OFF_IMASK:    rd_d = mask_q;
                OFF_MON_BYTE: rd_d = mon_q;
                OFF_LOOP0:    rd_d = loop_q[7:0];
                OFF_LOOP1:    rd_d = loop_q[15:8];
                OFF_LOOP2:    rd_d = loop_q[23:16];
                // R3: present condition, captured once per read
                OFF_RT_STAT:  rd_d = {7'h00, loss_q};
                default:      rd_d = 8'h00;
            endcase
        end
        // R2: R5: clear wins only without a fresh event
        lstat_d = (lstat_q & ~clr) | set;
        // R4: R14: low while any unmasked flag stands
        intn_d  = ~|(lstat_d & mask_d);
        // R7: pin follows the condition itself
        pin_d   = loss_d & loss_pin_enable;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            lstat_q <= RST_BYTE;
            mask_q  <= RST_BYTE;
            sel_q   <= RST_BYTE;
            loop_q  <= 24'h000000;
            rd_q    <= RST_BYTE;
            ack_q   <= 1'b0;
            intn_q  <= 1'b1;
            pin_q   <= 1'b0;
        end
        else
        begin
            lstat_q <= lstat_d;
            mask_q  <= mask_d;
            sel_q   <= sel_d;
            loop_q  <= loop_d;
            rd_q    <= rd_d;
            ack_q   <= ack_d;
            intn_q  <= intn_d;
            pin_q   <= pin_d;
        end
    end

    assign rp.ack            = ack_q;
    assign rp.rdata          = rd_q;
    assign rp.int_n          = intn_q;
    assign tx_clock_loss_pin = pin_q;
endmodule

// [core/t1tsl_host.sv]
`timescale 1ns/1ps
module t1tsl_host
(
    input  wire logic        aclk,    // System clock
    input  wire logic        aresetn, // Synchronous reset, low
    input  wire logic [7:0]  awaddr,  // Write address
    input  wire logic        awvalid, // Write address valid
    output logic             awready, // Write address ready
    input  wire logic [31:0] wdata,   // Write data
    input  wire logic [3:0]  wstrb,   // Byte strobes
    input  wire logic        wvalid,  // Write data valid
    output logic             wready,  // Write data ready
    output logic [1:0]       bresp,   // Write response
    output logic             bvalid,  // Write response valid
    input  wire logic        bready,  // Write response ready
    input  wire logic [7:0]  araddr,  // Read address
    input  wire logic        arvalid, // Read address valid
    output logic             arready, // Read address ready
    output logic [31:0]      rdata,   // Read data
    output logic [1:0]       rresp,   // Read response
    output logic             rvalid,  // Read data valid
    input  wire logic        rready,  // Read data ready
    t1tsl_if.host            rp       // Register port
);
    import t1tsl_pkg::*;

    // ------------------------------------------------------------
    // AXI4-Lite slave and port sequencer
    // ------------------------------------------------------------
    logic          awh_q, awh_d, wh_q, wh_d, bv_q, bv_d, rv_q, rv_d;
    logic [7:0]    awa_q, awa_d;
    logic [31:0]   wd_q, wd_d, rd_q, rd_d;
    logic [1:0]    br_q, br_d, rr_q, rr_d;
    logic [8:0]    addr_q, addr_d;
    logic          wr_q, wr_d, req_q, req_d;
    logic [7:0]    wb_q, wb_d, rb_q, rb_d;
    t1tsl_hstate_e st_q, st_d;

    // Address and data may come in either order; answer follows both
    always_comb
    begin
        awready = ~awh_q & ~bv_q;
        wready  = ~wh_q & ~bv_q;
        arready = ~rv_q;
        awh_d = awh_q | (awvalid & awready);
        wh_d  = wh_q | (wvalid & wready);
        awa_d = (awvalid & awready) ? awaddr : awa_q;
        // Strobe missing byte 0 or 1 marks bit 31 so no launch follows
        wd_d  = (wvalid & wready) ? {wdata[31] | (wstrb[1:0] != 2'b11), wdata[30:0]} : wd_q;
        bv_d  = bv_q & ~bready;
        br_d  = br_q;
        rv_d  = rv_q & ~rready;
        rd_d  = rd_q;
        rr_d  = rr_q;
        addr_d = addr_q;
        wr_d   = wr_q;
        wb_d   = wb_q;
        rb_d   = rb_q;
        req_d  = req_q;
        st_d   = st_q;
        if (awh_q & wh_q & ~bv_q)
        begin
            awh_d = 1'b0;
            wh_d  = 1'b0;
            bv_d  = 1'b1;
            br_d  = RESP_OKAY;
            case (awa_q)
                HOFF_CMD:
                begin
                    if (st_q != H_IDLE)
                    begin
                        // Busy: refuse rather than queue
                        br_d = RESP_SLVERR;
                    end
                    else if (wd_q[31:17] == 15'h0000)
                    begin
                        addr_d = wd_q[8:0];
                        wr_d   = wd_q[CMD_WR_BIT];
                        req_d  = 1'b1;
                        st_d   = H_ACCESS;
                        // R21: keep unused select bits zero
                        if (wd_q[8:0] == OFF_MON_SEL)
                        begin
                            wb_d = wb_q & MON_SEL_MASK;
                        end
                    end
                end
                HOFF_WDATA: wb_d = wd_q[7:0];
                default:    br_d = RESP_SLVERR;
            endcase
        end
        if (arvalid & arready)
        begin
            rv_d = 1'b1;
            rr_d = RESP_OKAY;
            case (araddr)
                HOFF_CMD:   rd_d = {15'h0000, wr_q, 7'h00, addr_q};
                HOFF_WDATA: rd_d = {24'h000000, wb_q};
                HOFF_STAT:  rd_d = {16'h0000, rb_q, 6'h00, ~rp.int_n,
                                    st_q != H_IDLE};
                default:
                begin
                    rd_d = 32'h00000000;
                    rr_d = RESP_SLVERR;
                end
            endcase
        end
        case (st_q)
            H_IDLE:   ;
            H_ACCESS:
            begin
                if (rp.ack)
                begin
                    req_d = 1'b0;
                    st_d  = H_IDLE;
                    if (!wr_q)
                    begin
                        rb_d = rp.rdata;
                    end
                end
            end
            default:  st_d = H_IDLE;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awh_q <= 1'b0;
            wh_q  <= 1'b0;
            bv_q  <= 1'b0;
            rv_q  <= 1'b0;
            awa_q <= 8'h00;
            wd_q  <= 32'h00000000;
            rd_q  <= 32'h00000000;
            br_q  <= RESP_OKAY;
            rr_q  <= RESP_OKAY;
            addr_q <= 9'h000;
            wr_q   <= 1'b0;
            wb_q   <= 8'h00;
            rb_q   <= 8'h00;
            req_q  <= 1'b0;
            st_q   <= H_IDLE;
        end
        else
        begin
            awh_q <= awh_d;
            wh_q  <= wh_d;
            bv_q  <= bv_d;
            rv_q  <= rv_d;
            awa_q <= awa_d;
            wd_q  <= wd_d;
            rd_q  <= rd_d;
            br_q  <= br_d;
            rr_q  <= rr_d;
            addr_q <= addr_d;
            wr_q   <= wr_d;
            wb_q   <= wb_d;
            rb_q   <= rb_d;
            req_q  <= req_d;
            st_q   <= st_d;
        end
    end

    assign bvalid   = bv_q;
    assign bresp    = br_q;
    assign rvalid   = rv_q;
    assign rdata    = rd_q;
    assign rresp    = rr_q;
    assign rp.req   = req_q;
    assign rp.wr    = wr_q;
    assign rp.addr  = addr_q;
    assign rp.wdata = wb_q;
endmodule

// [verif/t1tsl_asserts.sv]
`timescale 1ns/1ps
module t1tsl_asserts
    import t1tsl_pkg::*;
(
    input wire logic       aclk,    // Clock
    input wire logic       aresetn, // Reset, low
    input wire logic       req,     // Request
    input wire logic       wr,      // Write
    input wire logic [8:0] addr,    // Offset
    input wire logic [7:0] wdata,   // Write byte
    input wire logic [7:0] rdata,   // Read byte
    input wire logic       ack,     // Answer
    input wire logic       int_n    // Interrupt, low
);
    logic [7:0] mask_q, mask_d;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Mask shadow for readback and pin
    always_comb mask_d = (req && !ack && wr && addr == OFF_IMASK) ? wdata : mask_q;
    always_ff @(posedge aclk) mask_q <= aresetn ? mask_d : 8'h00;
    // ----
    // Properties
    // ----
    sequence s_rd(logic [8:0] a);
        req && !ack && !wr && addr == a;
    endsequence
    property p_ack_one;
        ack |=> !ack;
    endproperty
    property p_answer;
        req && !ack |=> ack;
    endproperty
    property p_cause;
        ack |-> $past(req);
    endproperty
    property p_rd_stable;
        !ack |-> $stable(rdata);
    endproperty
    property p_mask_rd;
        s_rd(OFF_IMASK) |=> rdata == mask_q;
    endproperty
    property p_sel_hi;
        s_rd(OFF_MON_SEL) |=> rdata[7:5] == 3'b000;
    endproperty
    property p_mask_off;
        mask_q == 8'h00 |-> int_n;
    endproperty
    property p_reset;
        $rose(aresetn) |-> int_n && !ack;
    endproperty
    a_ack_one: assert property (p_ack_one)
        else $error("ack longer than one cycle");
    a_answer: assert property (p_answer)
        else $error("request not answered next cycle");
    a_cause: assert property (p_cause)
        else $error("ack without request");
    a_rd_stable: assert property (p_rd_stable)
        else $error("read byte moved without ack");
    a_mask_rd: assert property (p_mask_rd)
        else $error("mask readback differs");
    a_sel_hi: assert property (p_sel_hi)
        else $error("select upper bits not zero");
    a_mask_off: assert property (p_mask_off)
        else $error("interrupt low with all masked");
    a_reset: assert property (p_reset)
        else $error("interrupt or ack after reset");
endmodule

// [verif/tb.sv]
`timescale 1ns/1ps
module tb;
    import t1tsl_pkg::*;
    logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0;
    logic        bready = 1, rready = 1, lclk = 0, fsync = 0, bp = 0, rx = 0, run = 1;
    logic        lpin_en = 0, awready, wready, bvalid, arready, rvalid, txd, lpin;
    logic [7:0]  awaddr = 0, araddr = 0, pos = 8'd192;
    logic [31:0] wdata = 0, rdata, r;
    logic [3:0]  wstrb = 0, ev = 0;
    logic [2:0]  ph = 0;
    logic [1:0]  bresp, rresp, rr;
    logic [7:0]  cap [24];
    int          fail_count, n_tests, cyc;
    // ----
    // Design and checker
    // ----
    t1tsl_if rp_if ();
    t1tsl_dev t1tsl_dev_inst (.aclk(aclk), .aresetn(aresetn), .rp(rp_if), .tx_line_clock(lclk),
        .tx_frame_sync(fsync), .tx_backplane_data(bp), .rx_line_data(rx), .d4_mode(1'b1),
        .slc_enable(1'b0), .density_violation(ev[0]), .store_slip(ev[1]), .store_empty(ev[2]),
        .store_full(ev[3]), .loss_pin_enable(lpin_en), .tx_line_data(txd),
        .tx_clock_loss_pin(lpin));
    t1tsl_host t1tsl_host_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .rp(rp_if));
    t1tsl_asserts t1tsl_asserts_inst (.aclk(aclk), .aresetn(aresetn), .req(rp_if.req),
        .wr(rp_if.wr), .addr(rp_if.addr), .wdata(rp_if.wdata), .rdata(rp_if.rdata),
        .ack(rp_if.ack), .int_n(rp_if.int_n));
    // Clock
    initial
    begin
        forever #50 aclk = ~aclk;
    end
    // Plain and looped channel bytes differ
    function automatic logic [7:0] ch_byte(input int c, input logic lb);
        return lb ? (8'h5A ^ 8'(c)) : {3'b101, 5'(c)};
    endfunction
    function automatic logic bit_at(input int p, input logic lb);
        logic [7:0] b;
        b = ch_byte(p / 8, lb);
        return (p > 191) ? 1'b0 : b[7 - p % 8];
    endfunction
    // shared timing
    // One line clock both ways, six cycles a bit
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (run)
        begin
            ph   <= (ph == 3'd5) ? 3'd0 : ph + 3'd1;
            lclk <= (ph == 3'd5) || (ph < 3'd2);
        end
        if (run && ph == 3'd5)
        begin
            pos   <= (pos == 8'd192) ? 8'd0 : pos + 8'd1;
            fsync <= (pos == 8'd192);
            bp    <= bit_at(pos, 1'b0);
            rx    <= bit_at(pos, 1'b1);
        end
        if (run && ph == 3'd4 && pos != 8'd0)
            cap[(pos - 8'd1) / 8][7 - (pos - 8'd1) % 8] <= txd;
    end
    // ----
    // Tasks
    // ----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw = 1'b0, w = 1'b0;
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= 4'hF;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        while (!(aw && w))
        begin
            @(posedge aclk);
            aw = aw || awready;
            w = w || wready;
            awvalid <= !aw;
            wvalid  <= !w;
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
    endtask
    task automatic axi_rd(input logic [7:0] a);
        araddr  <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        r = rdata;
        rr = rresp;
    endtask
    // Access via controller, poll until idle
    task automatic acc(input logic w, input logic [8:0] off, input logic [7:0] d);
        axi_wr(HOFF_WDATA, {24'h0, d});
        axi_wr(HOFF_CMD, {15'h0, w, 7'h0, off});
        do axi_rd(HOFF_STAT); while (r[STAT_BUSY] !== 1'b0);
    endtask
    task automatic wr(input logic [8:0] off, input logic [7:0] d);
        acc(1'b1, off, d);
    endtask
    task automatic rd_chk(input logic [8:0] off, input logic [7:0] exp);
        acc(1'b0, off, 8'h00);
        chk(r[15:8], exp);
    endtask
    task automatic frames(input int n);
        repeat (n) @(posedge aclk iff (run && ph == 3'd5 && pos == 8'd192));
    endtask
    task automatic wait_int();
        while (rp_if.int_n !== 1'b0) @(posedge aclk);
    endtask
    task automatic t_reset();
        logic [8:0] o [8] = '{OFF_MON_SEL, OFF_LSTAT, OFF_IMASK, OFF_MON_BYTE, OFF_LOOP0, OFF_LOOP1,
              OFF_LOOP2, 9'h000};
        foreach (o[i]) rd_chk(o[i], RST_BYTE);
        axi_rd(8'h0C);
        chk(rr, RESP_SLVERR);
        chk(rp_if.int_n, 1'b1);
    endtask
    task automatic t_events();
        int b [4] = '{BIT_DENSITY, BIT_SLIP, BIT_EMPTY, BIT_FULL};
        for (int i = 0; i < 4; i++)
        begin
            ev <= 4'(1 << i);
            @(posedge aclk);
            ev <= 4'h0;
            rd_chk(OFF_LSTAT, 8'(1 << b[i]));
            wr(OFF_LSTAT, 8'h00);
            rd_chk(OFF_LSTAT, 8'(1 << b[i]));
            chk(rp_if.int_n, 1'b1);
            wr(OFF_IMASK, 8'(1 << b[i]));
            chk(rp_if.int_n, 1'b0);
            wr(OFF_LSTAT, 8'(1 << b[i]));
            rd_chk(OFF_LSTAT, 8'h00);
            chk(rp_if.int_n, 1'b1);
            wr(OFF_IMASK, 8'h00);
        end
    endtask
    task automatic t_monitor();
        int c [3] = '{0, 5, 23};
        foreach (c[i])
        begin
            wr(OFF_MON_SEL, 8'hE0 | 8'(c[i]));
            rd_chk(OFF_MON_SEL, 8'(c[i]));
            frames(2);
            rd_chk(OFF_MON_BYTE, ch_byte(c[i], 1'b0));
        end
    endtask
    task automatic t_loop();
        wr(OFF_LOOP0, 8'h01);
        wr(OFF_LOOP1, 8'h80);
        wr(OFF_LOOP2, 8'hFF);
        rd_chk(OFF_LOOP1, 8'h80);
        frames(2);
        for (int c = 0; c < 24; c++) chk(cap[c], ch_byte(c, c == 0 || c > 14));
        for (int i = 0; i < 3; i++) wr(OFF_LOOP0 + 9'(i), 8'h00);
    endtask
    // Multiframe spacing between interrupts
    task automatic t_mframe();
        int t0;
        wr(OFF_IMASK, 8'h04);
        wr(OFF_LSTAT, 8'hFF);
        wait_int();
        t0 = cyc;
        wr(OFF_LSTAT, 8'h04);
        wait_int();
        chk(cyc - t0, 32'(D4_MF_FRAMES) * 193 * 6);
    endtask
    task automatic t_loss();
        lpin_en <= 1'b1;
        wr(OFF_IMASK, 8'h01);
        wr(OFF_LSTAT, 8'hFF);
        run <= 1'b0;
        repeat (5) @(posedge aclk);
        chk(lpin, 1'b0);
        repeat (LOSS_CYCLES + 5) @(posedge aclk);
        chk(lpin, 1'b1);
        chk(rp_if.int_n, 1'b0);
        rd_chk(OFF_RT_STAT, 8'h01);
        rd_chk(OFF_LSTAT, 8'h01);
        wr(OFF_LSTAT, 8'h01);
        rd_chk(OFF_LSTAT, 8'h00);
        chk(rp_if.int_n, 1'b1);
        chk(lpin, 1'b1);
        run <= 1'b1;
        repeat (LOSS_CYCLES) @(posedge aclk);
        chk(lpin, 1'b0);
        rd_chk(OFF_LSTAT, 8'h02);
    endtask
    // Main sequence; reset held three cycles
    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_events();
        t_monitor();
        t_loop();
        t_mframe();
        t_loss();
        stop_test();
    end
    // Watchdog past the longest run
    initial
    begin
        #6000000;
        fail_count++;
        stop_test();
    end
endmodule
